//--- hw/rfpm_top.sv
// fault protection manager for one output rail
`default_nettype none
`include "rfpm_cfg.svh"
module rfpm_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // rail control
  input wire logic enable_i,
  input wire logic [15:0] voltage_target_code_i,
  input wire logic target_transition_i,
  input wire logic multi_phase_state_i,
  input wire logic [2:0] phase_count_i,
  input wire logic [11:0] max_current_setting_i,
  input wire logic pwm_pulse_i,
  // comparators
  input wire logic oc_cmp_i,
  input wire logic ov_cmp_i,
  input wire logic uv_cmp_i,
  input wire logic below_release_cmp_i,
  // thresholds to comparators
  output logic [15:0] ov_thresh_mv_o,
  output logic [15:0] uv_thresh_mv_o,
  output logic [15:0] release_thresh_mv_o,
  output logic [15:0] oc_thresh_o,
  // outputs
  output logic power_good_out_o,
  output rfpm_pkg::rfpm_pwm_t pwm_mode_o,
  output rfpm_pkg::rfpm_ref_t ref_flag_o,
  output rfpm_pkg::rfpm_fault_t fault_o,
  output logic [15:0] internal_target_mv_o
);
  import rfpm_pkg::*;

  typedef enum logic [1:0] {
    RFPM_ST_RUN = 2'b00, RFPM_ST_OVHOLD = 2'b01, RFPM_ST_SHUT = 2'b10
  } rfpm_st_t;

  localparam int OC_CYC_I = `RFPM_OC_CYC;
  localparam int OV_CYC_I = `RFPM_OV_CYC;
  localparam int UV_CYC_I = `RFPM_UV_CYC;
  localparam logic [`RFPM_CNT_W-1:0] MASK_CYC = `RFPM_CNT_W'(`RFPM_MASK_CYC);
  localparam logic [`RFPM_CNT_W-1:0] RAMP_CYC = `RFPM_CNT_W'(`RFPM_RAMP_CYC);

  function automatic logic [15:0] ov_level(input logic [15:0] tgt);
    logic [15:0] sum;
    sum = tgt + `RFPM_OV_OFS_MV;
    ov_level = (sum < `RFPM_OV_FLOOR_MV) ? `RFPM_OV_FLOOR_MV : sum; // [RQ7]
  endfunction

  rfpm_st_t st_r;
  rfpm_fault_t fault_r;
  logic en_d_r;
  logic startup_r;
  logic from_zero_r;
  logic [`RFPM_CNT_W-1:0] mask_cnt_r;
  logic [`RFPM_CNT_W-1:0] ramp_cnt_r;
  logic [15:0] oc_lim_r;
  logic oc_lim_set_r;
  logic [15:0] int_tgt_r;
  logic [18:0] oc_full;
  logic [18:0] oc_div;
  logic tgt_zero;
  logic masked;
  logic en_toggle;
  logic trip_ov;
  logic trip_uv;
  logic trip_oc;

  rfpm_filt_if oc_f();
  rfpm_filt_if ov_f();
  rfpm_filt_if uv_f();

  assign tgt_zero = (voltage_target_code_i == 16'h0000);
  assign masked = target_transition_i || (mask_cnt_r != 12'h000);
  assign en_toggle = enable_i && !en_d_r;
  assign oc_f.cond = oc_cmp_i && !masked && !tgt_zero && (st_r == RFPM_ST_RUN); // [RQ2] [RQ16]
  assign ov_f.cond = ov_cmp_i && !tgt_zero && (st_r == RFPM_ST_RUN); // [RQ5] [RQ16]
  assign uv_f.cond = uv_cmp_i && !masked && (st_r == RFPM_ST_RUN); // [RQ12] [RQ16]
  assign trip_ov = ov_f.hit;
  assign trip_uv = uv_f.hit && !trip_ov;
  assign trip_oc = oc_f.hit && !trip_ov && !uv_f.hit;

  rfpm_filter #(.CYCLES(`RFPM_CNT_W'(OC_CYC_I))) u_oc_filt (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i || en_toggle), .f(oc_f)); // [RQ1]
  rfpm_filter #(.CYCLES(`RFPM_CNT_W'(OV_CYC_I))) u_ov_filt (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i || en_toggle), .f(ov_f)); // [RQ8]
  rfpm_filter #(.CYCLES(`RFPM_CNT_W'(UV_CYC_I))) u_uv_filt (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i || en_toggle), .f(uv_f)); // [RQ11]

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= enable_i;
    end
  end

  // mask window after transition settles
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || target_transition_i) begin
      mask_cnt_r <= MASK_CYC; // [RQ2] [RQ12]
    end else if (mask_cnt_r != 12'h000) begin
      mask_cnt_r <= mask_cnt_r - 12'h001;
    end
  end

  // startup ramp from zero until first pulse after settling
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      startup_r <= 1'b0;
    end else if (tgt_zero) begin
      startup_r <= 1'b1; // [RQ6]
    end else if (startup_r && !target_transition_i && pwm_pulse_i) begin
      startup_r <= 1'b0;
    end
  end

  // overcurrent limit captured once per enable; later writes ignored
  assign oc_full = 19'(max_current_setting_i) * 19'(`RFPM_OC_NUM);
  assign oc_div = oc_full / 19'(`RFPM_OC_DEN);
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || en_toggle) begin
      oc_lim_set_r <= 1'b0;
      oc_lim_r <= 16'h0000;
    end else if (!oc_lim_set_r) begin
      oc_lim_set_r <= 1'b1; // [RQ4]
      oc_lim_r <= oc_div[15:0]; // [RQ3]
    end
  end

  // fault latch and action state
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || en_toggle) begin
      st_r <= RFPM_ST_RUN; // [RQ13]
      fault_r <= RFPM_NONE;
      from_zero_r <= 1'b0;
    end else begin
      case (st_r)
        RFPM_ST_RUN: begin
          if (trip_ov) begin
            st_r <= RFPM_ST_OVHOLD; // [RQ8]
            fault_r <= RFPM_OV;
            from_zero_r <= startup_r;
          end else if (trip_uv) begin
            st_r <= RFPM_ST_SHUT; // [RQ11]
            fault_r <= RFPM_UV;
          end else if (trip_oc) begin
            st_r <= RFPM_ST_SHUT; // [RQ1]
            fault_r <= RFPM_OC;
          end
        end
        RFPM_ST_OVHOLD: begin
          if (below_release_cmp_i) begin
            st_r <= RFPM_ST_SHUT; // [RQ9]
          end
        end
        RFPM_ST_SHUT: st_r <= RFPM_ST_SHUT; // [RQ13]
        default: st_r <= RFPM_ST_RUN;
      endcase
    end
  end

  // ramp of internal target after overvoltage
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || en_toggle || fault_r != RFPM_OV) begin
      ramp_cnt_r <= 12'h000;
    end else if (ramp_cnt_r != RAMP_CYC) begin
      ramp_cnt_r <= ramp_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      int_tgt_r <= 16'h0000;
    end else if (fault_r == RFPM_OV && ramp_cnt_r == RAMP_CYC) begin
      if (int_tgt_r != 16'h0000) begin
        int_tgt_r <= int_tgt_r - `RFPM_RAMP_STEP_MV; // [RQ10]
      end
    end else if (fault_r == RFPM_NONE) begin
      int_tgt_r <= voltage_target_code_i;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      power_good_out_o <= 1'b0;
      pwm_mode_o <= RFPM_PWM_TRI;
      ref_flag_o <= RFPM_REF_NORMAL;
      fault_o <= RFPM_NONE;
      ov_thresh_mv_o <= `RFPM_OV_START_MV;
      uv_thresh_mv_o <= 16'h0000;
      release_thresh_mv_o <= `RFPM_OV_RELEASE_MV;
      oc_thresh_o <= 16'h0000;
      internal_target_mv_o <= 16'h0000;
    end else begin
      power_good_out_o <= (fault_r == RFPM_NONE) && enable_i && !trip_ov && !trip_uv
                          && !trip_oc; // [RQ1] [RQ8] [RQ11]
      if (trip_ov || st_r == RFPM_ST_OVHOLD) begin
        pwm_mode_o <= RFPM_PWM_LOW; // [RQ8] [RQ9]
      end else if (trip_uv || trip_oc || st_r == RFPM_ST_SHUT) begin
        pwm_mode_o <= RFPM_PWM_TRI; // [RQ1] [RQ10] [RQ11]
      end else begin
        pwm_mode_o <= RFPM_PWM_RUN;
      end
      case (fault_r)
        RFPM_OV: ref_flag_o <= RFPM_REF_1V0; // [RQ14]
        RFPM_UV: ref_flag_o <= RFPM_REF_1V5;
        RFPM_OC: ref_flag_o <= RFPM_REF_2V0;
        default: ref_flag_o <= RFPM_REF_NORMAL;
      endcase
      fault_o <= fault_r;
      ov_thresh_mv_o <= startup_r ? `RFPM_OV_START_MV : ov_level(voltage_target_code_i); // [RQ6]
      uv_thresh_mv_o <= (voltage_target_code_i > `RFPM_UV_OFS_MV) ?
                        voltage_target_code_i - `RFPM_UV_OFS_MV : 16'h0000; // [RQ11]
      release_thresh_mv_o <= from_zero_r ? `RFPM_OV_RELEASE_MV : int_tgt_r; // [RQ9]
      oc_thresh_o <= (multi_phase_state_i || phase_count_i == 3'h0) ? oc_lim_r :
                     oc_lim_r / 16'(phase_count_i); // [RQ3]
      internal_target_mv_o <= int_tgt_r;
    end
  end

  // multi-step trip reactions
  sequence s_ov_trip;
    st_r == RFPM_ST_RUN && trip_ov;
  endsequence
  sequence s_ov_latched;
    fault_r == RFPM_OV && pwm_mode_o == RFPM_PWM_LOW && !power_good_out_o
    ##1 fault_o == RFPM_OV;
  endsequence
  sequence s_uv_trip;
    st_r == RFPM_ST_RUN && trip_uv;
  endsequence
  sequence s_oc_trip;
    st_r == RFPM_ST_RUN && trip_oc;
  endsequence
  sequence s_tri_latched;
    st_r == RFPM_ST_SHUT && pwm_mode_o == RFPM_PWM_TRI && !power_good_out_o;
  endsequence
  sequence s_ov_release;
    st_r == RFPM_ST_OVHOLD && below_release_cmp_i;
  endsequence

  a_ref_flag_ov: assert property ( // [RQ14]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    $rose(fault_r == RFPM_OV) |=> ref_flag_o == RFPM_REF_1V0)
    else $error("reference flag not 1V after overvoltage");
  a_pg_low_latch: assert property ( // [RQ13]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    fault_r != RFPM_NONE |=> !power_good_out_o)
    else $error("power good high while faulted");
  a_ov_zero_mask: assert property ( // [RQ5]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    tgt_zero && st_r == RFPM_ST_RUN |=> st_r != RFPM_ST_OVHOLD)
    else $error("overvoltage tripped at zero target");
  a_ov_pwm_low: assert property ( // [RQ9]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    st_r == RFPM_ST_OVHOLD |=> pwm_mode_o == RFPM_PWM_LOW)
    else $error("pwm not low during overvoltage hold");
  a_no_pulse_shut: assert property ( // [RQ10]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    fault_r != RFPM_NONE |=> pwm_mode_o != RFPM_PWM_RUN)
    else $error("pwm running after trip");
  a_oc_masked: assert property ( // [RQ2]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    target_transition_i |-> !oc_f.cond && !uv_f.cond)
    else $error("fault armed during transition");
  a_oc_lim_hold: assert property ( // [RQ4]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    oc_lim_set_r && $past(oc_lim_set_r) |-> $stable(oc_lim_r))
    else $error("overcurrent limit changed at run time");
  a_ov_floor_thr: assert property ( // [RQ7]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !startup_r |=> ov_thresh_mv_o >= `RFPM_OV_FLOOR_MV)
    else $error("overvoltage threshold below floor");
  a_ov_trip_latch: assert property ( // [RQ8]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    s_ov_trip |=> s_ov_latched)
    else $error("overvoltage trip not latched with pwm low");
  a_uv_trip_tri: assert property ( // [RQ11]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    s_uv_trip |=> s_tri_latched ##1 fault_o == RFPM_UV && ref_flag_o == RFPM_REF_1V5)
    else $error("undervoltage trip not latched tristate");
  a_oc_trip_tri: assert property ( // [RQ1]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    s_oc_trip |=> s_tri_latched ##1 fault_o == RFPM_OC && ref_flag_o == RFPM_REF_2V0)
    else $error("overcurrent trip not latched tristate");
  a_ov_release_tri: assert property ( // [RQ9]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    s_ov_release |=> st_r == RFPM_ST_SHUT ##1 pwm_mode_o == RFPM_PWM_TRI)
    else $error("pwm not tristate after overvoltage release");
  a_ramp_step: assert property ( // [RQ10]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    fault_r == RFPM_OV && ramp_cnt_r == RAMP_CYC && int_tgt_r != 16'h0000
    |=> int_tgt_r == $past(int_tgt_r) - `RFPM_RAMP_STEP_MV)
    else $error("internal target not ramping down");
  a_ramp_hold: assert property ( // [RQ10]
    @(posedge sys_clk_i) disable iff (sys_rst_i || en_toggle)
    fault_r == RFPM_OV && ramp_cnt_r != RAMP_CYC |=> $stable(int_tgt_r))
    else $error("internal target moved before ramp delay");
  a_mask_reload: assert property ( // [RQ12]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(target_transition_i) |-> mask_cnt_r == MASK_CYC)
    else $error("mask window not restarted at settle");
  a_mask_blocks: assert property ( // [RQ2]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    masked && st_r == RFPM_ST_RUN |=> fault_r == RFPM_NONE || fault_r == RFPM_OV)
    else $error("masked fault latched");
  a_start_thr: assert property ( // [RQ6]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    startup_r |=> ov_thresh_mv_o == `RFPM_OV_START_MV)
    else $error("startup overvoltage threshold wrong");
  a_oc_thr_multi: assert property ( // [RQ3]
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    multi_phase_state_i |=> oc_thresh_o == $past(oc_lim_r))
    else $error("multi-phase overcurrent threshold scaled");
endmodule // rfpm_top
`default_nettype wire

//--- common/rfpm_cfg.svh
// timing counts, codes and threshold constants for the rail fault protection manager
// Overview of operation
// [RQ1] overcurrent held 40us: power good low, tristate
// [RQ2] overcurrent masked in transition, 80us, zero target
// [RQ3] overcurrent threshold 1.3 times setting, scaled
// [RQ4] runtime setting writes keep trip threshold
// [RQ5] overvoltage detection off at zero target
// [RQ6] startup ramp uses fixed 2.45V threshold
// [RQ7] threshold target plus 350mV, floor 1.35V
// [RQ8] overvoltage after 0.5us: power good low, low
// [RQ9] hold low until below 2.1V or target
// [RQ10] after 60us ramp target down, no pulses
// [RQ11] under target minus 650mV 3us: tristate
// [RQ12] undervoltage masked in transition plus 80us
// [RQ13] trips latch until supply or enable toggle
// [RQ14] reference flag 1V, 1.5V, 2V per fault
// [RQ15] filters are restarting persistence counters
// [RQ16] comparators are synchronous bits, threshold codes
`ifndef RFPM_CFG_SVH
`define RFPM_CFG_SVH
`define RFPM_CLK_MHZ 40
`define RFPM_OC_FILT_NS 40000
`define RFPM_MASK_NS 80000
`define RFPM_OV_FILT_NS 500
`define RFPM_RAMP_DLY_NS 60000
`define RFPM_UV_FILT_NS 3000
`define RFPM_OC_CYC ((`RFPM_OC_FILT_NS * `RFPM_CLK_MHZ + 999) / 1000)
`define RFPM_MASK_CYC ((`RFPM_MASK_NS * `RFPM_CLK_MHZ + 999) / 1000)
`define RFPM_OV_CYC ((`RFPM_OV_FILT_NS * `RFPM_CLK_MHZ + 999) / 1000)
`define RFPM_RAMP_CYC ((`RFPM_RAMP_DLY_NS * `RFPM_CLK_MHZ + 999) / 1000)
`define RFPM_UV_CYC ((`RFPM_UV_FILT_NS * `RFPM_CLK_MHZ + 999) / 1000)
`define RFPM_CNT_W 12
// millivolt levels; target code is in millivolts
`define RFPM_OV_START_MV 16'd2450
`define RFPM_OV_OFS_MV 16'd350
`define RFPM_OV_FLOOR_MV 16'd1350
`define RFPM_OV_RELEASE_MV 16'd2100
`define RFPM_UV_OFS_MV 16'd650
// overcurrent scale 1.3 as 13/10
`define RFPM_OC_NUM 5'd13
`define RFPM_OC_DEN 5'd10
`define RFPM_RAMP_STEP_MV 16'h0001
`endif

//--- common/rfpm_pkg.sv
// types shared by the rail fault protection manager
`default_nettype none
package rfpm_pkg;
  typedef enum logic [1:0] {
    RFPM_NONE = 2'b00, RFPM_OV = 2'b01, RFPM_UV = 2'b10, RFPM_OC = 2'b11
  } rfpm_fault_t;
  typedef enum logic [1:0] {
    RFPM_PWM_RUN = 2'b00, RFPM_PWM_LOW = 2'b01, RFPM_PWM_TRI = 2'b10
  } rfpm_pwm_t;
  // flag level codes on the reference output
  typedef enum logic [1:0] {
    RFPM_REF_NORMAL = 2'b00, RFPM_REF_1V0 = 2'b01, RFPM_REF_1V5 = 2'b10, RFPM_REF_2V0 = 2'b11
  } rfpm_ref_t;
endpackage
`default_nettype wire

//--- common/rfpm_filt_if.sv
// persistence filter connection
`default_nettype none
interface rfpm_filt_if;
  logic cond;
  logic hit;
  modport ctl (output cond, input hit);
  modport flt (input cond, output hit);
endinterface
`default_nettype wire

//--- hw/rfpm_filter.sv
// persistence counter: hit once cond has held for cycles
`default_nettype none
`include "rfpm_cfg.svh"
module rfpm_filter #(
  parameter logic [`RFPM_CNT_W-1:0] CYCLES = 12'h001
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  rfpm_filt_if.flt f
);
  logic [`RFPM_CNT_W-1:0] cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !f.cond) begin
      cnt_r <= 12'h000; // [RQ15]
    end else if (cnt_r != CYCLES) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  assign f.hit = f.cond && (cnt_r == CYCLES - 12'h001 || cnt_r == CYCLES);
endmodule // rfpm_filter
`default_nettype wire

//--- verif/rfpm_stage_model.sv
// comparator and current sense model of the rail power stage
`default_nettype none
module rfpm_stage_model (
  // clock and sensed levels
  input wire logic sys_clk_i,
  input wire logic [15:0] vout_mv_i,
  input wire logic [15:0] isum_i,
  // thresholds from the manager
  input wire logic [15:0] ov_thr_i,
  input wire logic [15:0] uv_thr_i,
  input wire logic [15:0] rel_thr_i,
  input wire logic [15:0] oc_thr_i,
  // comparator outputs
  output logic ov_o = 1'b0,
  output logic uv_o = 1'b0,
  output logic rel_o = 1'b0,
  output logic oc_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered, so the manager sees one cycle of comparator lag
  always @(posedge sys_clk_i) begin
    ov_o <= vout_mv_i > ov_thr_i;
    uv_o <= vout_mv_i < uv_thr_i;
    rel_o <= vout_mv_i < rel_thr_i;
    oc_o <= isum_i > oc_thr_i;
  end
endmodule // rfpm_stage_model
`default_nettype wire

//--- verif/test_rfpm_top.sv
// self-checking bench for the rail fault protection manager
`default_nettype none
module test_rfpm_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rfpm_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic enable_i = 1'b0;
  logic [15:0] tgt = 16'h0000;
  logic trans = 1'b0;
  logic multi = 1'b1;
  logic [2:0] pcnt = 3'h1;
  logic [11:0] imax = 12'h000;
  logic pulse = 1'b0;
  logic oc, ov, uv, rel, pg;
  logic [15:0] ov_thr, uv_thr, rel_thr, oc_thr, itgt;
  logic [15:0] vout = 16'h0000;
  logic [15:0] isum = 16'h0000;
  rfpm_pwm_t pwm;
  rfpm_ref_t rflag;
  rfpm_fault_t flt;
  int mismatches = 0;
  int comparisons = 0;
  int t, s, i;
  int tv[$] = {900, 1000, 1001, 1600};
  always #12.5 sys_clk_i = ~sys_clk_i;
  rfpm_top rfpm_top_i (.sys_clk_i, .sys_rst_i, .enable_i, .voltage_target_code_i(tgt),
    .target_transition_i(trans), .multi_phase_state_i(multi), .phase_count_i(pcnt),
    .max_current_setting_i(imax), .pwm_pulse_i(pulse), .oc_cmp_i(oc), .ov_cmp_i(ov),
    .uv_cmp_i(uv), .below_release_cmp_i(rel), .ov_thresh_mv_o(ov_thr), .uv_thresh_mv_o(uv_thr),
    .release_thresh_mv_o(rel_thr), .oc_thresh_o(oc_thr), .power_good_out_o(pg),
    .pwm_mode_o(pwm), .ref_flag_o(rflag), .fault_o(flt), .internal_target_mv_o(itgt));
  rfpm_stage_model rfpm_stage_model_i (.sys_clk_i, .vout_mv_i(vout), .isum_i(isum),
    .ov_thr_i(ov_thr), .uv_thr_i(uv_thr), .rel_thr_i(rel_thr), .oc_thr_i(oc_thr),
    .ov_o(ov), .uv_o(uv), .rel_o(rel), .oc_o(oc));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // bounded wait for a latched fault
  task automatic trip(input int n, input rfpm_fault_t f);
    for (int k = 0; k < n && flt === RFPM_NONE; k++) cyc(1);
    chk(flt, f);
  endtask
  task automatic toggle_en();
    enable_i = 1'b0;
    cyc(2);
    enable_i = 1'b1;
    cyc(3);
  endtask
  function automatic int ovt(input int v);
    return (v + 350 < 1350) ? 1350 : v + 350;
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1500000;
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(91));
    t = 1000 + $urandom % 600;
    s = 600 * (1 + $urandom % 6);
    cyc(6);
    chk(pg, 0);
    chk(pwm, RFPM_PWM_TRI);
    chk(ov_thr, 2450);
    chk(rel_thr, 2100);
    sys_rst_i = 1'b0;
    imax = s[11:0];
    vout = 16'd1000;
    enable_i = 1'b1;
    cyc(3);
    tgt = t[15:0];
    trans = 1'b1;
    cyc(5);
    trans = 1'b0;
    cyc(3);
    chk(ov_thr, 2450);
    pulse = 1'b1;
    cyc(1);
    pulse = 1'b0;
    cyc(3);
    chk(ov_thr, ovt(t));
    chk(uv_thr, t - 650);
    chk(pg, 1);
    foreach (tv[j]) begin
      tgt = tv[j][15:0];
      cyc(3);
      chk(ov_thr, ovt(tv[j]));
    end
    tgt = t[15:0];
    for (i = 1; i < 7; i++) begin
      pcnt = i[2:0];
      multi = 1'b0;
      cyc(3);
      chk(oc_thr, s * 13 / 10 / i);
      multi = 1'b1;
      cyc(3);
      chk(oc_thr, s * 13 / 10);
    end
    imax = 12'($urandom);
    cyc(3);
    chk(oc_thr, s * 13 / 10);
    trans = 1'b1;
    isum = 16'hffff;
    vout = 16'h0000;
    cyc(2000);
    chk(flt, RFPM_NONE);
    trans = 1'b0;
    cyc(3150);
    chk(flt, RFPM_NONE);
    trip(200, RFPM_UV);
    chk(pwm, RFPM_PWM_TRI);
    chk(pg, 0);
    cyc(2);
    chk(rflag, RFPM_REF_1V5);
    isum = 16'h0000;
    vout = 16'd1000;
    cyc(2000);
    chk(flt, RFPM_UV);
    toggle_en();
    chk(flt, RFPM_NONE);
    chk(pg, 1);
    cyc(3300);
    isum = 16'hffff;
    cyc(1500);
    isum = 16'h0000;
    cyc(2);
    isum = 16'hffff;
    cyc(1590);
    chk(flt, RFPM_NONE);
    trip(20, RFPM_OC);
    chk(pwm, RFPM_PWM_TRI);
    chk(pg, 0);
    cyc(2);
    chk(rflag, RFPM_REF_2V0);
    isum = 16'h0000;
    toggle_en();
    vout = 16'd3000;
    cyc(15);
    vout = 16'd1000;
    cyc(3);
    chk(flt, RFPM_NONE);
    vout = 16'd3000;
    trip(30, RFPM_OV);
    chk(pwm, RFPM_PWM_LOW);
    chk(pg, 0);
    cyc(100);
    chk(pwm, RFPM_PWM_LOW);
    chk(rflag, RFPM_REF_1V0);
    vout = 16'(t - 10);
    cyc(4);
    chk(pwm, RFPM_PWM_TRI);
    chk(itgt, t);
    for (i = 0; i < 2600; i++) begin
      cyc(1);
      if (pwm === RFPM_PWM_RUN) chk(pwm, RFPM_PWM_TRI);
    end
    chk(itgt < t - 220 && itgt > t - 380, 1);
    enable_i = 1'b0;
    tgt = 16'h0000;
    vout = 16'd3000;
    cyc(2);
    enable_i = 1'b1;
    cyc(100);
    chk(flt, RFPM_NONE);
    vout = 16'd2400;
    tgt = t[15:0];
    trans = 1'b1;
    cyc(60);
    chk(flt, RFPM_NONE);
    vout = 16'd2500;
    trip(30, RFPM_OV);
    chk(rel_thr, 2100);
    vout = 16'd2200;
    cyc(20);
    chk(pwm, RFPM_PWM_LOW);
    vout = 16'd2000;
    cyc(4);
    chk(pwm, RFPM_PWM_TRI);
    conclude();
  end
endmodule // test_rfpm_top
`default_nettype wire
